/* File: src/clock_flag_pkg.sv */
package clock_flag_pkg;

  // ********************************************************
  // Clock source codes
  // ********************************************************
  localparam logic [1:0] SRC_RECOVERED = 2'h0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h2;
  localparam logic [1:0] SRC_RESERVED = 2'h3;
  localparam logic [1:0] PORT_SRC_RESET = 2'h1;

  // ********************************************************
  // Clock mode and fallback codes
  // ********************************************************
  localparam logic [1:0] CM_RECOVERED = 2'h0;
  localparam logic [1:0] CM_ALTERNATE = 2'h1;
  localparam logic [1:0] CM_AUTO = 2'h2;
  localparam logic [1:0] CM_ALT_ALWAYS = 2'h3;
  localparam logic FALLBACK_CRYSTAL = 1'b0;

  // ********************************************************
  // Master clock output speed
  // ********************************************************
  localparam logic [1:0] SPEED_512FS = 2'h2;
  localparam logic [1:0] SPEED_128FS = 2'h3;
  typedef enum logic [1:0] {RATIO_256FS, RATIO_512FS, RATIO_128FS} mclk_ratio_t;

  // ********************************************************
  // Flag pin and zero grouping
  // ********************************************************
  localparam logic [1:0] FUNC_OFF = 2'h0;
  localparam logic [1:0] FUNC_OVERFLOW = 2'h1;
  localparam logic [1:0] FUNC_ZERO = 2'h2;
  localparam logic [1:0] FUNC_VALIDITY = 2'h3;
  localparam logic [1:0] ZG_ALL = 2'h0;
  localparam logic [1:0] ZG_PAIR1 = 2'h1;
  localparam logic [1:0] ZG_PAIR2 = 2'h2;
  localparam int DAC_CH = 4;
  localparam logic [DAC_CH-1:0] ZMASK_ALL = 4'hF;
  localparam logic [DAC_CH-1:0] ZMASK_PAIR1 = 4'h3;
  localparam logic [DAC_CH-1:0] ZMASK_PAIR2 = 4'hC;
  localparam logic [DAC_CH-1:0] ZMASK_NONE = 4'h0;

  // ********************************************************
  // Detection timing, in sample or frame periods
  // ********************************************************
  localparam int ADC_W = 24;
  localparam logic [ADC_W-1:0] OVF_LIMIT = 24'h7BA78E;
  localparam int OVF_DELAY_SAMPLES = 16;
  localparam int OVF_HOLDOFF_SAMPLES = 522;
  localparam int HOLDOFF_W = 10;
  localparam int ZERO_FRAMES = 8192;
  localparam logic FLAG_RESET = 1'b0;

  // ********************************************************
  // Serial port pins
  // ********************************************************
  localparam int PIN_N = 5;
  localparam int PIN_ONE_IN_FRAME = 0;
  localparam int PIN_ONE_OUT_FRAME = 1;
  localparam int PIN_ONE_BIT = 2;
  localparam int PIN_TWO_FRAME = 3;
  localparam int PIN_TWO_BIT = 4;
  localparam logic [PIN_N-1:0] PIN_MASK_ONE = 5'h07;
  localparam logic [PIN_N-1:0] PIN_MASK_TWO = 5'h18;

  typedef struct packed {
    logic [1:0] clock_mode_sel;
    logic fallback_clock_sel;
    logic [1:0] mclk_out_speed;
    logic [1:0] mclk_out_source;
    logic [1:0] port_one_clock_source;
    logic [1:0] port_two_clock_source;
    logic adc_on_port_two;
    logic dac_on_port_two;
  } clk_cfg_t;

  typedef struct packed {
    logic port_a_role;
    logic port_b_role;
    logic port_a_in_auto_ratio;
    logic port_a_out_auto_ratio;
    logic port_b_auto_ratio;
  } port_cfg_t;

  typedef struct packed {
    logic [1:0] flag_pin_function;
    logic [1:0] zero_group_sel;
  } flag_cfg_t;

endpackage : clock_flag_pkg

/* File: src/clock_select_and_flag_pin.sv */
`timescale 1ns/1ps
`default_nettype none

module clock_select_and_flag_pin #(
  parameter int ZERO_FRAMES_P = clock_flag_pkg::ZERO_FRAMES,
  parameter logic [clock_flag_pkg::ADC_W-1:0] OVF_LIMIT_P = clock_flag_pkg::OVF_LIMIT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_down_pin_n_i,
  input wire logic recovered_clock_i,
  input wire logic crystal_clock_i,
  input wire logic external_master_clock_i,
  input wire logic receiver_unlock_i,
  input wire logic receiver_power_down_i,
  input wire logic validity_bit_i,
  input wire clock_flag_pkg::clk_cfg_t clk_cfg_i,
  input wire clock_flag_pkg::port_cfg_t port_cfg_i,
  input wire clock_flag_pkg::flag_cfg_t flag_cfg_i,
  input wire logic [clock_flag_pkg::PIN_N-1:0] port_pin_i,
  input wire logic [clock_flag_pkg::PIN_N-1:0] port_pin_gen_i,
  input wire logic adc_sample_i,
  input wire logic signed [clock_flag_pkg::ADC_W-1:0] adc_left_i,
  input wire logic signed [clock_flag_pkg::ADC_W-1:0] adc_right_i,
  input wire logic dac_frame_i,
  input wire logic [clock_flag_pkg::DAC_CH-1:0] dac_nonzero_i,
  output logic master_clock_output_o,
  output clock_flag_pkg::mclk_ratio_t mclk_ratio_o,
  output logic [1:0] mclk_source_o,
  output logic port_one_clk_o,
  output logic port_two_clk_o,
  output logic adc_clk_o,
  output logic dac_clk_o,
  output logic [clock_flag_pkg::PIN_N-1:0] port_pin_o,
  output logic [clock_flag_pkg::PIN_N-1:0] port_pin_oe_o,
  output logic [clock_flag_pkg::PIN_N-1:0] port_pin_in_o,
  output logic [2:0] auto_ratio_eff_o,
  output logic flag_pin_o
);
  import clock_flag_pkg::*;

  localparam int ZERO_W = $clog2(ZERO_FRAMES_P + 1);
  localparam logic [ZERO_W-1:0] ZERO_DONE = ZERO_W'(ZERO_FRAMES_P);
  localparam logic [HOLDOFF_W-1:0] HOLDOFF_DONE = HOLDOFF_W'(OVF_HOLDOFF_SAMPLES);

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [6:0] sync_q;
  logic rec_s;
  logic xtal_s;
  logic ext_s;
  logic unlock_s;
  logic rpd_s;
  logic valid_s;
  logic pdn_s;

  level_sync #(.W(7)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({recovered_clock_i, crystal_clock_i, external_master_clock_i, receiver_unlock_i,
          receiver_power_down_i, validity_bit_i, power_down_pin_n_i}),
    .q_o(sync_q)
  );
  assign {rec_s, xtal_s, ext_s, unlock_s, rpd_s, valid_s, pdn_s} = sync_q;

  level_sync #(.W(PIN_N)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(port_pin_i),
    .q_o(port_pin_in_o)
  );

  // ********************************************************
  // Clock source resolution
  // ********************************************************
  function automatic logic [1:0] resolve(input logic [1:0] code, input logic use_alt,
                                         input logic fb);
    resolve = code;
    if (code == SRC_RECOVERED && use_alt) begin
      resolve = fb ? SRC_EXTERNAL : SRC_CRYSTAL;
    end
  endfunction : resolve

  function automatic logic pick(input logic [1:0] code, input logic r, input logic x,
                                input logic e);
    case (code)
      SRC_RECOVERED: pick = r;
      SRC_CRYSTAL: pick = x;
      SRC_EXTERNAL: pick = e;
      default: pick = 1'b0;
    endcase
  endfunction : pick

  logic use_alt;
  logic [1:0] nxt_mclk_src_ff, mclk_src_ff;
  logic [1:0] p1_src, p2_src;
  logic nxt_mclk_ff, mclk_ff;
  mclk_ratio_t nxt_ratio_ff, ratio_ff;
  logic nxt_p1_clk_ff, p1_clk_ff;
  logic nxt_p2_clk_ff, p2_clk_ff;
  logic nxt_adc_clk_ff, adc_clk_ff;
  logic nxt_dac_clk_ff, dac_clk_ff;
  logic master_one, master_two;
  logic [PIN_N-1:0] pin_master;
  logic [PIN_N-1:0] nxt_pin_o_ff, pin_o_ff;
  logic [PIN_N-1:0] nxt_pin_oe_ff, pin_oe_ff;
  logic [2:0] nxt_auto_ff, auto_ff;

  always_comb begin
    case (clk_cfg_i.clock_mode_sel)
      CM_RECOVERED: use_alt = 1'b0;
      CM_ALTERNATE: use_alt = 1'b1;
      CM_AUTO: use_alt = unlock_s | rpd_s;
      default: use_alt = 1'b1;
    endcase
  end

  assign master_one = port_cfg_i.port_a_role & pdn_s;
  assign master_two = port_cfg_i.port_b_role & pdn_s;
  assign pin_master = (master_one ? PIN_MASK_ONE : '0) | (master_two ? PIN_MASK_TWO : '0);

  always_comb begin
    nxt_mclk_src_ff = resolve(clk_cfg_i.mclk_out_source, use_alt,
                              clk_cfg_i.fallback_clock_sel);
    p1_src = resolve(clk_cfg_i.port_one_clock_source, use_alt,
                     clk_cfg_i.fallback_clock_sel);
    p2_src = resolve(clk_cfg_i.port_two_clock_source, use_alt,
                     clk_cfg_i.fallback_clock_sel);
    nxt_mclk_ff = pick(nxt_mclk_src_ff, rec_s, xtal_s, ext_s);
    nxt_p1_clk_ff = pick(p1_src, rec_s, xtal_s, ext_s);
    nxt_p2_clk_ff = pick(p2_src, rec_s, xtal_s, ext_s);
    nxt_adc_clk_ff = clk_cfg_i.adc_on_port_two ? nxt_p2_clk_ff : nxt_p1_clk_ff;
    nxt_dac_clk_ff = clk_cfg_i.dac_on_port_two ? nxt_p2_clk_ff : nxt_p1_clk_ff;
    case (clk_cfg_i.mclk_out_speed)
      SPEED_512FS: nxt_ratio_ff = RATIO_512FS;
      SPEED_128FS: nxt_ratio_ff = RATIO_128FS;
      default: nxt_ratio_ff = RATIO_256FS;
    endcase
    nxt_pin_oe_ff = pin_master;
    nxt_pin_o_ff = pin_master & port_pin_gen_i;
    nxt_auto_ff = {port_cfg_i.port_b_auto_ratio & ~master_two,
                   port_cfg_i.port_a_out_auto_ratio & ~master_one,
                   port_cfg_i.port_a_in_auto_ratio & ~master_one};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mclk_src_ff <= PORT_SRC_RESET;
      mclk_ff <= 1'b0;
      ratio_ff <= RATIO_256FS;
      p1_clk_ff <= 1'b0;
      p2_clk_ff <= 1'b0;
      adc_clk_ff <= 1'b0;
      dac_clk_ff <= 1'b0;
      pin_o_ff <= '0;
      pin_oe_ff <= '0;
      auto_ff <= '0;
    end else begin
      mclk_src_ff <= nxt_mclk_src_ff;
      mclk_ff <= nxt_mclk_ff;
      ratio_ff <= nxt_ratio_ff;
      p1_clk_ff <= nxt_p1_clk_ff;
      p2_clk_ff <= nxt_p2_clk_ff;
      adc_clk_ff <= nxt_adc_clk_ff;
      dac_clk_ff <= nxt_dac_clk_ff;
      pin_o_ff <= nxt_pin_o_ff;
      pin_oe_ff <= nxt_pin_oe_ff;
      auto_ff <= nxt_auto_ff;
    end
  end

  assign master_clock_output_o = mclk_ff;
  assign mclk_ratio_o = ratio_ff;
  assign mclk_source_o = mclk_src_ff;
  assign port_one_clk_o = p1_clk_ff;
  assign port_two_clk_o = p2_clk_ff;
  assign adc_clk_o = adc_clk_ff;
  assign dac_clk_o = dac_clk_ff;
  assign port_pin_o = pin_o_ff;
  assign port_pin_oe_o = pin_oe_ff;
  assign auto_ratio_eff_o = auto_ff;

  // ********************************************************
  // Flag pin: overflow, zero and validity detection
  // ********************************************************
  logic ovf_now;
  logic ovf_ok;
  logic [OVF_DELAY_SAMPLES-1:0] nxt_ovf_pipe_ff, ovf_pipe_ff;
  logic [HOLDOFF_W-1:0] nxt_holdoff_ff, holdoff_ff;
  logic [DAC_CH-1:0] zmask;
  logic any_nz;
  logic all_zero;
  logic [ZERO_W-1:0] nxt_zero_cnt_ff, zero_cnt_ff;
  logic nxt_zero_ff, zero_ff;
  logic nxt_flag_ff, flag_ff;
  logic nxt_ovf_out_ff, ovf_out_ff;

  // Samples arrive post high-pass filter, ahead of the attenuator
  assign ovf_now = (adc_left_i > $signed(OVF_LIMIT_P)) || (adc_left_i < -$signed(OVF_LIMIT_P))
    || (adc_right_i > $signed(OVF_LIMIT_P)) || (adc_right_i < -$signed(OVF_LIMIT_P));
  assign ovf_ok = (holdoff_ff == HOLDOFF_DONE);

  always_comb begin
    case (flag_cfg_i.zero_group_sel)
      ZG_ALL: zmask = ZMASK_ALL;
      ZG_PAIR1: zmask = ZMASK_PAIR1;
      ZG_PAIR2: zmask = ZMASK_PAIR2;
      default: zmask = ZMASK_NONE;
    endcase
  end

  assign any_nz = |(zmask & dac_nonzero_i);
  assign all_zero = (zmask != ZMASK_NONE) && !any_nz;

  always_comb begin
    nxt_ovf_pipe_ff = ovf_pipe_ff;
    nxt_holdoff_ff = holdoff_ff;
    nxt_ovf_out_ff = ovf_out_ff;
    if (!pdn_s) begin
      nxt_ovf_pipe_ff = '0;
      nxt_ovf_out_ff = 1'b0;
      nxt_holdoff_ff = '0;
    end else if (adc_sample_i) begin
      // Taken on the 16th strobe after the over-range sample
      nxt_ovf_out_ff = ovf_pipe_ff[OVF_DELAY_SAMPLES-1] && ovf_ok;
      nxt_ovf_pipe_ff = {ovf_pipe_ff[OVF_DELAY_SAMPLES-2:0], ovf_now};
      if (!ovf_ok) begin
        nxt_holdoff_ff = holdoff_ff + HOLDOFF_W'(1);
      end
    end
    nxt_zero_cnt_ff = zero_cnt_ff;
    if (!all_zero) begin
      nxt_zero_cnt_ff = '0;
    end else if (dac_frame_i && zero_cnt_ff != ZERO_DONE) begin
      nxt_zero_cnt_ff = zero_cnt_ff + ZERO_W'(1);
    end
    nxt_zero_ff = all_zero && (nxt_zero_cnt_ff == ZERO_DONE);
    case (flag_cfg_i.flag_pin_function)
      FUNC_OVERFLOW: nxt_flag_ff = ovf_out_ff;
      FUNC_ZERO: nxt_flag_ff = nxt_zero_ff;
      FUNC_VALIDITY: nxt_flag_ff = valid_s && !unlock_s;
      default: nxt_flag_ff = FLAG_RESET;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_pipe_ff <= '0;
      holdoff_ff <= '0;
      zero_cnt_ff <= '0;
      zero_ff <= 1'b0;
      flag_ff <= FLAG_RESET;
      ovf_out_ff <= 1'b0;
    end else begin
      ovf_out_ff <= nxt_ovf_out_ff;
      ovf_pipe_ff <= nxt_ovf_pipe_ff;
      holdoff_ff <= nxt_holdoff_ff;
      zero_cnt_ff <= nxt_zero_cnt_ff;
      zero_ff <= nxt_zero_ff;
      flag_ff <= nxt_flag_ff;
    end
  end

  assign flag_pin_o = flag_ff;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_auto_locked;
    clk_cfg_i.clock_mode_sel == CM_AUTO && !unlock_s && !rpd_s
      && clk_cfg_i.mclk_out_source == SRC_RECOVERED |=> mclk_src_ff == SRC_RECOVERED;
  endproperty
  a_auto_locked: assert property (p_auto_locked) else $error("auto mode lost recovered");

  property p_auto_fallback;
    clk_cfg_i.clock_mode_sel == CM_AUTO && unlock_s && clk_cfg_i.mclk_out_source == SRC_RECOVERED
      |=> mclk_src_ff == ($past(clk_cfg_i.fallback_clock_sel) ? SRC_EXTERNAL : SRC_CRYSTAL);
  endproperty
  a_auto_fallback: assert property (p_auto_fallback) else $error("bad fallback clock");

  property p_alt_always;
    clk_cfg_i.clock_mode_sel == CM_ALT_ALWAYS && !clk_cfg_i.fallback_clock_sel
      |=> mclk_src_ff != SRC_RECOVERED;
  endproperty
  a_alt_always: assert property (p_alt_always) else $error("recovered used in mode 11");

  property p_ratio;
    clk_cfg_i.mclk_out_speed == SPEED_128FS |=> mclk_ratio_o == RATIO_128FS;
  endproperty
  a_ratio: assert property (p_ratio) else $error("wrong clock ratio");

  property p_slave_pd;
    !pdn_s |=> port_pin_oe_o == '0;
  endproperty
  a_slave_pd: assert property (p_slave_pd) else $error("pin driven in power-down");

  property p_oe_role;
    !port_cfg_i.port_a_role |=> (port_pin_oe_o & PIN_MASK_ONE) == '0 && !port_pin_o[PIN_ONE_BIT];
  endproperty
  a_oe_role: assert property (p_oe_role) else $error("slave port drives pin");

  property p_auto_master;
    master_two |=> !auto_ratio_eff_o[2];
  endproperty
  a_auto_master: assert property (p_auto_master) else $error("auto ratio in master");

  property p_flag_off;
    flag_cfg_i.flag_pin_function == FUNC_OFF |=> !flag_pin_o;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag high when off");

  property p_holdoff;
    $fell(pdn_s) ##1 pdn_s [*8] |-> !ovf_ok;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("overflow enabled early");

  property p_zero_drop;
    flag_cfg_i.flag_pin_function == FUNC_ZERO && any_nz |=> !flag_pin_o && !zero_ff;
  endproperty
  a_zero_drop: assert property (p_zero_drop) else $error("zero flag stuck high");

  property p_validity;
    flag_cfg_i.flag_pin_function == FUNC_VALIDITY && unlock_s |=> !flag_pin_o;
  endproperty
  a_validity: assert property (p_validity) else $error("validity high when unlocked");

  property p_dac_clk;
    clk_cfg_i.dac_on_port_two |=> dac_clk_o == port_two_clk_o;
  endproperty
  a_dac_clk: assert property (p_dac_clk) else $error("converter clock mismatch");

  property p_c_fallback;
    clk_cfg_i.clock_mode_sel == CM_AUTO ##1 $rose(unlock_s);
  endproperty
  c_fallback: cover property (p_c_fallback);

  property p_c_zero;
    $rose(zero_ff);
  endproperty
  c_zero: cover property (p_c_zero);

  property p_c_ovf;
    flag_cfg_i.flag_pin_function == FUNC_OVERFLOW && $rose(flag_pin_o);
  endproperty
  c_ovf: cover property (p_c_ovf);

endmodule : clock_select_and_flag_pin

`default_nettype wire

/* File: src/level_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // ********************************************************
  // Two-stage synchroniser
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule : level_sync

`default_nettype wire

/* File: verification/clock_select_and_flag_pin_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module clock_select_and_flag_pin_tb_top;
  import clock_flag_pkg::*;
  localparam int ZF = 8;
  localparam logic signed [ADC_W-1:0] OVR = OVF_LIMIT + 24'h000001;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pdn_n = 1'b0;
  logic rec = 1'b1;
  logic cry = 1'b0;
  logic ext = 1'b1;
  logic unlock = 1'b0;
  logic rx_pd = 1'b0;
  logic valid = 1'b0;
  clk_cfg_t cc = '0;
  port_cfg_t pc = '0;
  flag_cfg_t fc = '0;
  logic [PIN_N-1:0] far_val = 5'h0A;
  logic [PIN_N-1:0] gen = 5'h15;
  logic [PIN_N-1:0] pin_wire;
  logic adc_s = 1'b0;
  logic signed [ADC_W-1:0] adc_l = '0;
  logic signed [ADC_W-1:0] adc_r = '0;
  logic dac_f = 1'b0;
  logic [DAC_CH-1:0] nonzero = '0;
  logic mclk_o, p1_clk, p2_clk, adc_clk, dac_clk, flag;
  mclk_ratio_t ratio;
  logic [1:0] src;
  logic [PIN_N-1:0] pin_o, pin_oe, pin_in;
  logic [2:0] eff;
  int n_mismatch = 0;
  int checks = 0;

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  clock_select_and_flag_pin #(.ZERO_FRAMES_P(ZF)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .power_down_pin_n_i(pdn_n), .recovered_clock_i(rec), .crystal_clock_i(cry),
    .external_master_clock_i(ext), .receiver_unlock_i(unlock), .receiver_power_down_i(rx_pd),
    .validity_bit_i(valid), .clk_cfg_i(cc), .port_cfg_i(pc), .flag_cfg_i(fc),
    .port_pin_i(pin_wire), .port_pin_gen_i(gen), .adc_sample_i(adc_s), .adc_left_i(adc_l),
    .adc_right_i(adc_r), .dac_frame_i(dac_f), .dac_nonzero_i(nonzero),
    .master_clock_output_o(mclk_o), .mclk_ratio_o(ratio), .mclk_source_o(src),
    .port_one_clk_o(p1_clk), .port_two_clk_o(p2_clk), .adc_clk_o(adc_clk),
    .dac_clk_o(dac_clk), .port_pin_o(pin_o), .port_pin_oe_o(pin_oe), .port_pin_in_o(pin_in),
    .auto_ratio_eff_o(eff), .flag_pin_o(flag));

  pin_far_side far (.pin_i(pin_o), .oe_i(pin_oe), .far_val_i(far_val), .wire_o(pin_wire));

  // ********************************************************
  // Shared helpers
  // ********************************************************
  task settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task strobe(input logic signed [ADC_W-1:0] l, input logic signed [ADC_W-1:0] r);
    @(posedge clk_i);
    adc_s <= 1'b1;
    adc_l <= l;
    adc_r <= r;
    @(posedge clk_i);
    adc_s <= 1'b0;
    settle(1);
  endtask : strobe

  task frame;
    @(posedge clk_i);
    dac_f <= 1'b1;
    @(posedge clk_i);
    dac_f <= 1'b0;
    settle(1);
  endtask : frame

  // ********************************************************
  // Scenarios
  // ********************************************************
  task t_roles;
    @(posedge clk_i);
    pc <= '1;
    settle(4);
    chk("oe_pdn_low", 5'h00, pin_oe);
    chk("pin_in", far_val, pin_in);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      pdn_n <= 1'b1;
      pc.port_a_role <= (k == 0);
      pc.port_b_role <= (k == 1);
      settle(4);
      chk("oe", (k == 0) ? 5'h07 : (k == 1) ? 5'h18 : 5'h00, pin_oe);
      chk("pin_o", (k == 0) ? gen & 5'h07 : (k == 1) ? gen & 5'h18 : 5'h00, pin_o);
      chk("auto_eff", (k == 0) ? 3'h4 : (k == 1) ? 3'h3 : 3'h7, eff);
    end
  endtask : t_roles

  task t_source;
    logic [1:0] e;
    for (int m = 0; m < 32; m++) begin
      @(posedge clk_i);
      cc.clock_mode_sel <= m[1:0];
      cc.fallback_clock_sel <= m[2];
      unlock <= m[3];
      rx_pd <= m[4];
      cc.mclk_out_source <= SRC_RECOVERED;
      cc.port_two_clock_source <= SRC_RECOVERED;
      e = (m[1:0] == CM_RECOVERED || (m[1:0] == CM_AUTO && m[4:3] == 2'h0)) ? SRC_RECOVERED
        : (m[2] ? SRC_EXTERNAL : SRC_CRYSTAL);
      settle(4);
      chk("mclk_source", e, src);
      chk("mclk_level", e != SRC_CRYSTAL, mclk_o);
      chk("port_two_level", e != SRC_CRYSTAL, p2_clk);
    end
    for (int s = 1; s < 4; s++) begin
      @(posedge clk_i);
      {rec, cry, ext} <= 3'h7;
      cc.clock_mode_sel <= CM_RECOVERED;
      cc.mclk_out_source <= s[1:0];
      cc.port_one_clock_source <= s[1:0];
      settle(4);
      if (s < 3) chk("mclk_source", s[1:0], src);
      chk("mclk_level", s < 3, mclk_o);
      chk("port_one_level", s < 3, p1_clk);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      {rec, cry, ext} <= 3'h2;
      cc.port_one_clock_source <= SRC_CRYSTAL;
      cc.port_two_clock_source <= SRC_EXTERNAL;
      cc.adc_on_port_two <= (k == 0);
      cc.dac_on_port_two <= (k == 1);
      settle(4);
      chk("adc_clk", k == 1, adc_clk);
      chk("dac_clk", k == 0, dac_clk);
    end
  endtask : t_source

  task t_speed;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      cc.mclk_out_speed <= s[1:0];
      settle(2);
      chk("ratio", (s == 2) ? RATIO_512FS : (s == 3) ? RATIO_128FS : RATIO_256FS, ratio);
    end
  endtask : t_speed

  task t_overflow;
    @(posedge clk_i);
    fc.flag_pin_function <= FUNC_OVERFLOW;
    pdn_n <= 1'b0;
    settle(4);
    @(posedge clk_i);
    pdn_n <= 1'b1;
    settle(4);
    for (int i = 0; i < 500; i++) begin
      strobe(OVR, '0);
      chk("ovf_holdoff", 1'b0, flag);
    end
    repeat (40) strobe('0, '0);
    strobe('0, -OVR);
    chk("ovf_early", 1'b0, flag);
    for (int i = 1; i <= 16; i++) begin
      strobe(OVF_LIMIT, -OVF_LIMIT);
      chk("ovf_delay", i == 16, flag);
    end
    strobe('0, '0);
    chk("ovf_limit", 1'b0, flag);
  endtask : t_overflow

  task t_zero;
    logic [3:0] m;
    @(posedge clk_i);
    fc.flag_pin_function <= FUNC_ZERO;
    for (int g = 0; g < 4; g++) begin
      m = (g == 0) ? ZMASK_ALL : (g == 1) ? ZMASK_PAIR1 : (g == 2) ? ZMASK_PAIR2 : ZMASK_NONE;
      @(posedge clk_i);
      fc.zero_group_sel <= g[1:0];
      nonzero <= 4'hF;
      settle(2);
      @(posedge clk_i);
      nonzero <= ~m;
      settle(1);
      for (int i = 0; i < ZF; i++) begin
        chk("zero_early", 1'b0, flag);
        frame();
      end
      chk("zero_flag", m != 4'h0, flag);
      @(posedge clk_i);
      nonzero <= ~m | (m & ~(m - 4'h1));
      settle(1);
      chk("zero_drop", 1'b0, flag);
    end
  endtask : t_zero

  task t_validity;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      fc.flag_pin_function <= (k == 2) ? FUNC_OFF : FUNC_VALIDITY;
      valid <= 1'b1;
      unlock <= (k == 1);
      settle(4);
      chk("validity", k == 0, flag);
    end
  endtask : t_validity

  task report_and_stop;
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial begin
    settle(7);
    chk("reset_source", PORT_SRC_RESET, src);
    chk("reset_flag", 1'b0, flag);
    @(posedge clk_i);
    rst_i <= 1'b0;
    settle(3);
    t_roles();
    t_source();
    t_speed();
    t_overflow();
    t_zero();
    t_validity();
    report_and_stop();
  end
endmodule : clock_select_and_flag_pin_tb_top

`default_nettype wire

/* File: verification/pin_far_side.sv */
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// Far side of the serial port clock pins
// ********************************************************
module pin_far_side (
  input wire logic [clock_flag_pkg::PIN_N-1:0] pin_i,
  input wire logic [clock_flag_pkg::PIN_N-1:0] oe_i,
  input wire logic [clock_flag_pkg::PIN_N-1:0] far_val_i,
  output logic [clock_flag_pkg::PIN_N-1:0] wire_o
);
  import clock_flag_pkg::*;
  // A pin the codec does not drive carries the far-side master clock level
  assign wire_o = (oe_i & pin_i) | (~oe_i & far_val_i);
endmodule : pin_far_side

`default_nettype wire
